// ==== hw/lsft_ctrl.v ====
// Fault timing controller for a current-limited load switch
`timescale 1ns/10ps
`default_nettype none
`include "lsft_regs.vh"

module lsft_ctrl #(
  parameter BLANK_MS   = `LSFT_BLANK_MS,
  parameter RETRY_MS   = `LSFT_RETRY_MS,
  parameter CYC_PER_MS = `LSFT_CYC_PER_MS
) (
  // Clock and reset
  input  wire mclk_in,
  input  wire rst_n_in,
  // Host side
  input  wire switch_on_in,
  output reg  fault_flag_n_out,
  output reg  fault_flag_oe_out,
  // Analog sense indications
  input  wire oc_fwd_in,
  input  wire oc_rev_in,
  input  wire over_temp_in,
  // Variant strap, high selects retry
  input  wire retry_mode_in,
  // Power switch gate
  output reg  switch_close_out
);

  // **********************************************************
  // Timing
  // **********************************************************
  // A shortened blanking figure is raised to the floor
  localparam BLANK_EFF = (BLANK_MS < `LSFT_BLANK_MIN_MS) ?
                         `LSFT_BLANK_MIN_MS : BLANK_MS;
  localparam integer BLANK_LAST_I = BLANK_EFF - 1;
  localparam integer RETRY_LAST_I = RETRY_MS - 1;
  // Counts are cut to the counter width on purpose
  localparam [`LSFT_MS_CNT_W-1:0] BLANK_LAST =
    BLANK_LAST_I[`LSFT_MS_CNT_W-1:0];
  localparam [`LSFT_MS_CNT_W-1:0] RETRY_LAST =
    RETRY_LAST_I[`LSFT_MS_CNT_W-1:0];

  // **********************************************************
  // Input synchronisers
  // **********************************************************
  // Bit 0 on, 1 forward oc, 2 reverse oc, 3 over temperature
  wire [3:0] raw_in;
  reg  [3:0] sync1;
  reg  [3:0] sync2;
  reg  [3:0] sync3;
  reg  [3:0] filt;

  assign raw_in = {over_temp_in, oc_rev_in, oc_fwd_in, switch_on_in};

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      filt  <= 4'h0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      // A bit moves only once the last two stages agree
      filt  <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end
  end

  wire on_lvl;
  wire oc_lvl;
  wire ot_lvl;

  assign on_lvl = filt[0];
  assign oc_lvl = filt[1] | filt[2];
  assign ot_lvl = filt[3];

  // **********************************************************
  // Variant strap
  // **********************************************************
  // The strap is static, so one sample after release is enough
  reg strap_done;
  reg retry_mode;

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_done <= 1'b0;
      retry_mode <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      retry_mode <= retry_mode_in;
    end
  end

  // **********************************************************
  // Millisecond time base
  // **********************************************************
  wire tick;
  reg  restart;

  lsft_tick #(
    .CYC_PER_TICK (CYC_PER_MS),
    .CNT_W        (`LSFT_TICK_W)
  ) u_tick (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .clear_in (restart),
    .tick_out (tick)
  );

  // **********************************************************
  // State machine
  // **********************************************************
  reg [2:0]                  state;
  reg [2:0]                  next_state;
  reg [`LSFT_MS_CNT_W-1:0]   ms_cnt;
  reg [`LSFT_MS_CNT_W-1:0]   next_ms_cnt;
  reg                        flag_hold;
  reg                        next_flag_hold;
  reg                        next_switch;
  reg                        next_flag;

  always @* begin
    next_state     = state;
    next_ms_cnt    = ms_cnt;
    next_flag_hold = flag_hold;
    restart        = 1'b0;
    if (!on_lvl) begin
      // Shutdown overrides every fault and clears latch-off
      next_state     = `LSFT_ST_OFF;
      next_flag_hold = 1'b0;
    end else begin
      case (state)
        `LSFT_ST_OFF: begin
          // A hot die must not see the switch close even for one cycle
          if (ot_lvl) begin
            next_state = `LSFT_ST_THERM;
          end else begin
            next_state = `LSFT_ST_RUN;
          end
        end
        `LSFT_ST_RUN: begin
          if (ot_lvl) begin
            next_state = `LSFT_ST_THERM;
          end else if (oc_lvl) begin
            next_state  = `LSFT_ST_BLANK;
            next_ms_cnt = {`LSFT_MS_CNT_W{1'b0}};
            restart     = 1'b1;
          end
        end
        `LSFT_ST_BLANK: begin
          if (ot_lvl) begin
            next_state = `LSFT_ST_THERM;
          end else if (!oc_lvl) begin
            // Short episode: back to normal, flag released if a retry had asserted it
            next_state     = `LSFT_ST_RUN;
            next_ms_cnt    = {`LSFT_MS_CNT_W{1'b0}};
            next_flag_hold = 1'b0;
          end else if (tick) begin
            if (ms_cnt == BLANK_LAST) begin
              next_ms_cnt = {`LSFT_MS_CNT_W{1'b0}};
              if (retry_mode) begin
                next_state     = `LSFT_ST_RETRY;
                next_flag_hold = 1'b1;
                restart        = 1'b1;
              end else begin
                next_state = `LSFT_ST_LATCH;
              end
            end else begin
              next_ms_cnt = ms_cnt + {{(`LSFT_MS_CNT_W-1){1'b0}}, 1'b1};
            end
          end
        end
        `LSFT_ST_RETRY: begin
          if (ot_lvl) begin
            next_state = `LSFT_ST_THERM;
          end else if (tick) begin
            if (ms_cnt == RETRY_LAST) begin
              // Reclose and blank again; the flag stays low meanwhile
              next_state  = `LSFT_ST_BLANK;
              next_ms_cnt = {`LSFT_MS_CNT_W{1'b0}};
              restart     = 1'b1;
            end else begin
              next_ms_cnt = ms_cnt + {{(`LSFT_MS_CNT_W-1){1'b0}}, 1'b1};
            end
          end
        end
        `LSFT_ST_LATCH: begin
          next_state = `LSFT_ST_LATCH;
        end
        `LSFT_ST_THERM: begin
          // Latch-off parts stay here until the on input is cycled
          if (!ot_lvl && retry_mode) begin
            next_state     = `LSFT_ST_RUN;
            next_flag_hold = 1'b0;
            next_ms_cnt    = {`LSFT_MS_CNT_W{1'b0}};
          end
        end
        default: begin
          next_state = `LSFT_ST_OFF;
        end
      endcase
    end
  end

  // Outputs follow the next state so they change with it
  always @* begin
    case (next_state)
      `LSFT_ST_RUN: begin
        next_switch = 1'b1;
        next_flag   = 1'b0;
      end
      `LSFT_ST_BLANK: begin
        next_switch = 1'b1;
        next_flag   = next_flag_hold;
      end
      `LSFT_ST_RETRY: begin
        next_switch = 1'b0;
        next_flag   = 1'b1;
      end
      `LSFT_ST_LATCH: begin
        next_switch = 1'b0;
        next_flag   = 1'b1;
      end
      `LSFT_ST_THERM: begin
        next_switch = 1'b0;
        next_flag   = 1'b1;
      end
      default: begin
        next_switch = 1'b0;
        next_flag   = 1'b0;
      end
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state             <= `LSFT_ST_OFF;
      ms_cnt            <= {`LSFT_MS_CNT_W{1'b0}};
      flag_hold         <= 1'b0;
      switch_close_out  <= 1'b0;
      fault_flag_oe_out <= 1'b0;
      fault_flag_n_out  <= 1'b0;
    end else begin
      state             <= next_state;
      ms_cnt            <= next_ms_cnt;
      flag_hold         <= next_flag_hold;
      switch_close_out  <= next_switch;
      // Open drain: pull low when asserting, otherwise released
      fault_flag_oe_out <= next_flag;
      fault_flag_n_out  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== hw/lsft_regs.vh ====
// Timing constants for the load switch fault timer
`ifndef LSFT_REGS_VH
`define LSFT_REGS_VH

// **********************************************************
// Time base
// **********************************************************
`define LSFT_CLK_NS       10
`define LSFT_MS_NS        1000000
`define LSFT_CYC_PER_MS   (`LSFT_MS_NS / `LSFT_CLK_NS)
`define LSFT_TICK_W       17

// **********************************************************
// Fault timing in milliseconds, and its counter width in bits
// **********************************************************
`define LSFT_BLANK_MS     37
`define LSFT_BLANK_MIN_MS 14
`define LSFT_RETRY_MS     555
`define LSFT_MS_CNT_W     10

// **********************************************************
// Controller states
// **********************************************************
`define LSFT_ST_OFF       3'h0
`define LSFT_ST_RUN       3'h1
`define LSFT_ST_BLANK     3'h2
`define LSFT_ST_RETRY     3'h3
`define LSFT_ST_LATCH     3'h4
`define LSFT_ST_THERM     3'h5

`endif

// ==== hw/lsft_tick.v ====
// Restartable millisecond tick divider
`timescale 1ns/10ps
`default_nettype none

module lsft_tick #(
  parameter CYC_PER_TICK = 100000,
  parameter CNT_W        = 17
) (
  // Clock and reset
  input  wire mclk_in,
  input  wire rst_n_in,
  // Control
  input  wire clear_in,
  // Tick
  output reg  tick_out
);

  // The count is cut to the counter width on purpose
  localparam integer     LAST_I = CYC_PER_TICK - 1;
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

  reg [CNT_W-1:0] cnt;

  // Restart aligns the first tick to a full period after the clear,
  // so a timer started with it never runs short
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt      <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end else if (clear_in) begin
      cnt      <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end else if (cnt == LAST) begin
      cnt      <= {CNT_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      cnt      <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== sim/lsft_host.sv ====
// Host model: drives the switch-on pin and reads the flag through a pull-up
`timescale 1ns/10ps
`default_nettype none

module lsft_host (
  // Command from the bench
  input  wire logic want_on_in,
  // Device pins
  input  wire logic flag_oe_in,
  output wire logic switch_on_out,
  output wire logic flag_pin_out
);
  // Recovery from a latch is only ever a low-then-high on this pin
  assign switch_on_out = want_on_in;
  // External pull-up: released pin reads high, never the stale value
  assign flag_pin_out  = flag_oe_in ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// ==== sim/lsft_ctrl_asserts.sv ====
// Concurrent checks on the ports of the fault timing controller
`timescale 1ns/10ps
`default_nettype none

module lsft_ctrl_asserts #(
  parameter BLANK_MS   = 37,
  parameter RETRY_MS   = 555,
  parameter CYC_PER_MS = 100000
) (
  // Clock, reset and inputs
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic switch_on_in,
  input wire logic oc_fwd_in,
  input wire logic oc_rev_in,
  input wire logic over_temp_in,
  input wire logic retry_mode_in,
  // Outputs
  input wire logic fault_flag_n_out,
  input wire logic fault_flag_oe_out,
  input wire logic switch_close_out
);
  localparam int BMS = (BLANK_MS < 14) ? 14 : BLANK_MS;
  localparam int BLK = BMS * CYC_PER_MS;
  localparam int RTY = RETRY_MS * CYC_PER_MS;
  localparam int QT  = RTY + 12;
  wire oc = oc_fwd_in | oc_rev_in;
  int  oc_run;
  int  open_run;
  int  quiet_run;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // Run lengths let the long timers be checked without huge repetitions
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_run    <= 0;
      open_run  <= 0;
      quiet_run <= 0;
    end else begin
      oc_run    <= oc ? oc_run + 1 : 0;
      open_run  <= switch_close_out ? 0 : open_run + 1;
      quiet_run <= (switch_on_in && !oc && !over_temp_in) ?
                   ((quiet_run < QT) ? quiet_run + 1 : quiet_run) : 0;
    end
  end

  off_open_a: assert property
    (!switch_on_in [*8] |-> !switch_close_out && !fault_flag_oe_out)
    else $error("Switch or flag active while off");
  flag_drive_a: assert property
    (fault_flag_n_out == 1'b0) else $error("Flag pin driven high");
  temp_trip_a: assert property
    ((switch_on_in && over_temp_in) [*8] |->
      !switch_close_out && fault_flag_oe_out) else $error("No thermal trip");
  blank_floor_a: assert property
    ($rose(fault_flag_oe_out) && !over_temp_in |-> oc_run >= BLK)
    else $error("Flag before blanking ran out");
  retry_len_a: assert property
    ($rose(switch_close_out) && fault_flag_oe_out && retry_mode_in |->
      open_run >= RTY - 2 && open_run <= RTY + 3)
    else $error("Retry off time wrong");
  latch_hold_a: assert property
    ((switch_on_in [*6] ##0 (fault_flag_oe_out && !retry_mode_in))
      ##1 switch_on_in |-> fault_flag_oe_out && !switch_close_out)
    else $error("Latched state left without on toggle");
  clear_close_a: assert property
    (retry_mode_in && quiet_run >= QT |->
      switch_close_out && !fault_flag_oe_out)
    else $error("Switch not closed after fault cleared");
  open_flagged_a: assert property
    (switch_on_in [*8] ##0 !switch_close_out |-> fault_flag_oe_out)
    else $error("Switch open without a flag");

  cover property ($rose(switch_close_out) && fault_flag_oe_out);
  cover property ($rose(fault_flag_oe_out) && !retry_mode_in);
  cover property ($rose(fault_flag_oe_out) && over_temp_in);
endmodule

bind lsft_ctrl lsft_ctrl_asserts #(
  .BLANK_MS(BLANK_MS), .RETRY_MS(RETRY_MS), .CYC_PER_MS(CYC_PER_MS)
) chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .switch_on_in(switch_on_in),
  .oc_fwd_in(oc_fwd_in), .oc_rev_in(oc_rev_in),
  .over_temp_in(over_temp_in), .retry_mode_in(retry_mode_in),
  .fault_flag_n_out(fault_flag_n_out),
  .fault_flag_oe_out(fault_flag_oe_out),
  .switch_close_out(switch_close_out)
);

`default_nettype wire

// ==== sim/lsft_ctrl_tb.sv ====
// Self-checking bench for the load switch fault timing controller
`timescale 1ns/10ps
`default_nettype none

module lsft_ctrl_tb;
  // Short millisecond keeps the run small; expectations scale with it
  localparam int CPM = 10;
  localparam int BMS = 14;
  localparam int RMS = 5;
  logic mclk_in, rst_n_in, want_on, oc_fwd, oc_rev, temp, mode;
  wire  logic sw_on, flag_n, flag_oe, sw_close, flag_pin;
  int   err_total, checked, seed, n, cyc;

  lsft_ctrl #(.BLANK_MS(BMS), .RETRY_MS(RMS), .CYC_PER_MS(CPM)) DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .switch_on_in(sw_on),
    .fault_flag_n_out(flag_n), .fault_flag_oe_out(flag_oe),
    .oc_fwd_in(oc_fwd), .oc_rev_in(oc_rev), .over_temp_in(temp),
    .retry_mode_in(mode), .switch_close_out(sw_close));
  lsft_host host (.want_on_in(want_on), .flag_oe_in(flag_oe),
    .switch_on_out(sw_on), .flag_pin_out(flag_pin));

  function automatic int blank_cyc();
    return BMS * CPM;
  endfunction
  function automatic int retry_cyc();
    return RMS * CPM;
  endfunction

  task automatic check(string name, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b got %b", name, exp, got);
    end
  endtask
  task automatic check_rng(string name, int lo, int hi, int got);
    checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("ERROR %s expected %0d..%0d got %0d", name, lo, hi, got);
    end
  endtask
  task automatic cyc_n(int k);
    repeat (k) @(negedge mclk_in);
  endtask
  task automatic wait_for(bit sel, logic v, int lim, output int c);
    c = 0;
    while ((sel ? sw_close : flag_oe) !== v && c < lim) begin
      @(negedge mclk_in);
      c++;
    end
  endtask
  task automatic restart(logic m);
    mode = m;
    rst_n_in = 1'b0;
    want_on = 1'b1;
    {oc_fwd, oc_rev, temp} = 3'h0;
    cyc_n(5);
    rst_n_in = 1'b1;
    cyc_n(10);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      $display("ERROR run expected end got timeout");
      final_report();
    end
  end

  initial begin
    seed = 74174;
    restart(1'b1);
    check("close_idle", 1'b1, sw_close);
    // Short episodes back to back: their sum far exceeds blanking
    repeat (6) begin
      n = 3 + ($unsigned($random(seed)) % (blank_cyc() - 20));
      if ($random(seed) & 1) oc_fwd = 1'b1;
      else oc_rev = 1'b1;
      cyc_n(n);
      {oc_fwd, oc_rev} = 2'h0;
      cyc_n(4);
      check("flag_short", 1'b1, flag_pin);
    end
    oc_rev = 1'b1;
    wait_for(0, 1'b1, blank_cyc() + 20, n);
    check_rng("blank_len", blank_cyc(), blank_cyc() + 8, n);
    check("retry_open", 1'b0, sw_close);
    wait_for(1, 1'b1, retry_cyc() + 20, n);
    check_rng("retry_len", retry_cyc() - 2, retry_cyc() + 3, n);
    check("flag_reblank", 1'b0, flag_pin);
    wait_for(1, 1'b0, blank_cyc() + 20, n);
    check_rng("reblank", blank_cyc() - 2, blank_cyc() + 3, n);
    oc_rev = 1'b0;
    wait_for(0, 1'b0, retry_cyc() + 20, n);
    check("close_after", 1'b1, sw_close);
    check("flag_clear", 1'b1, flag_pin);
    temp = 1'b1;
    cyc_n(20);
    check("temp_open", 1'b0, sw_close);
    check("temp_flag", 1'b0, flag_pin);
    temp = 1'b0;
    cyc_n(10);
    check("temp_back", 1'b1, sw_close);
    {want_on, temp, oc_fwd} = 3'h3;
    cyc_n(10);
    check("off_flag", 1'b1, flag_pin);
    check("off_open", 1'b0, sw_close);
    check("flag_data", 1'b0, flag_n);
    restart(1'b0);
    oc_fwd = 1'b1;
    wait_for(0, 1'b1, blank_cyc() + 20, n);
    check_rng("latch_blank", blank_cyc(), blank_cyc() + 8, n);
    oc_fwd = 1'b0;
    cyc_n(100);
    check("latch_hold", 1'b0, sw_close);
    want_on = 1'b0;
    cyc_n(8);
    want_on = 1'b1;
    cyc_n(8);
    check("latch_toggle", 1'b1, sw_close);
    temp = 1'b1;
    cyc_n(10);
    temp = 1'b0;
    cyc_n(20);
    check("temp_latch", 1'b0, sw_close);
    restart(1'b0);
    check("power_up", 1'b1, sw_close);
    final_report();
  end
endmodule

`default_nettype wire
